/* rtl/e1toi_insert.sv */
// ============================================================
// transmit E1 slot-0 overhead insertion with host registers
//
// Summary of operation
// - remote alarm values register, bit 7 frame 1 down to bit 0 frame 15.
// - additional bit 4 values register, bit 7 frame 1 to bit 0 frame 15.
// - additional bit 5 values register, bit 7 frame 1 to bit 0 frame 15.
// - additional bit 6 values register, bit 7 frame 1 to bit 0 frame 15.
// - additional bit 7 values register, bit 7 frame 1 to bit 0 frame 15.
// - additional bit 8 values register, bit 7 frame 1 to bit 0 frame 15.
// - control bit 0 set inserts additional bit 8 values, clear does not.
// - control bit 1 set inserts additional bit 7 values, clear does not.
// - control bit 2 set inserts additional bit 6 values, clear does not.
// - control bit 3 set inserts additional bit 5 values, clear does not.
// - control bit 4 set inserts additional bit 4 values, clear does not.
// - control bit 5 set inserts remote alarm values, clear does not.
// - control bit 6 set inserts nonalign international bits, clear does not.
// - control bit 7 set inserts align international bits, clear does not.
// - align international values, bit 7 frame 0 down to bit 0 frame 14.
// - nonalign international values, bit 7 frame 1 to bit 0 frame 15.
// - remote alarm values register sits at address d4h.
module e1toi_insert
    import e1toi_pkg::*;
#(
    parameter int unsigned ADDR_W = E1TOI_ADDR_W
) (
    input  wire logic              clk_in,         // transmit framer clock
    input  wire logic              srst_in,        // synchronous reset, high
    input  wire logic [ADDR_W-1:0] cpu_addr_in,    // register address
    input  wire logic              cpu_wr_in,      // write strobe, one cycle
    input  wire logic              cpu_rd_in,      // read strobe, one cycle
    input  wire logic [7:0]        cpu_wdata_in,   // write data
    output logic [7:0]             cpu_rdata_out,  // read data
    output logic                   cpu_rvalid_out, // read data valid pulse
    input  wire logic              ts0_valid_in,   // slot-0 byte present
    input  wire logic [3:0]        ts0_frame_in,   // frame number in multiframe
    input  wire logic [7:0]        ts0_data_in,    // upstream slot-0 byte
    output logic                   ts0_valid_out,  // slot-0 byte present
    output logic [3:0]             ts0_frame_out,  // frame number, delayed
    output logic [7:0]             ts0_data_out,   // slot-0 byte after insertion
    output logic [7:0]             ts0_mask_out    // lanes replaced in this byte
);

    // ============================================================
    // elaboration checks
    if (ADDR_W < E1TOI_ADDR_W) begin : g_bad_addr
        $error("e1toi_insert: address width below 8 bits");
    end

    // ============================================================
    // register file state
    logic [7:0] val_q [E1TOI_NSRC];
    logic [7:0] val_d [E1TOI_NSRC];
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       rvalid_q;
    logic       rvalid_d;

    // address decode, one hot per source register
    logic [E1TOI_NSRC-1:0] sel_val;
    logic                  sel_ctrl;

    for (genvar s = 0; s < E1TOI_NSRC; s++) begin : g_dec
        // remote alarm slot decodes at d4h
        assign sel_val[s] = (cpu_addr_in == ADDR_W'(E1TOI_SRC_OFS[s]));
    end
    assign sel_ctrl = (cpu_addr_in == ADDR_W'(E1TOI_OFS_CTRL));

    // ============================================================
    // register writes and reads
    always_comb begin
        for (int s = 0; s < E1TOI_NSRC; s++) begin
            val_d[s] = val_q[s];
            if (cpu_wr_in && sel_val[s]) begin
                // bit 7 is the first frame of the set, bit 0 the last
                val_d[s] = cpu_wdata_in;
            end
        end
        ctrl_d = ctrl_q;
        if (cpu_wr_in && sel_ctrl) begin
            ctrl_d = cpu_wdata_in;
        end
        // a write and a read to the same address in one cycle read old data
        rdata_d  = rdata_q;
        rvalid_d = 1'b0;
        if (cpu_rd_in) begin
            rvalid_d = 1'b1;
            rdata_d  = E1TOI_UNMAPPED;
            if (sel_ctrl) begin
                rdata_d = ctrl_q;
            end
            for (int s = 0; s < E1TOI_NSRC; s++) begin
                if (sel_val[s]) begin
                    rdata_d = val_q[s];
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            for (int s = 0; s < E1TOI_NSRC; s++) begin
                val_q[s] <= E1TOI_RST_VAL;
            end
            ctrl_q   <= E1TOI_RST_CTRL;
            rdata_q  <= E1TOI_UNMAPPED;
            rvalid_q <= 1'b0;
        end else begin
            for (int s = 0; s < E1TOI_NSRC; s++) begin
                val_q[s] <= val_d[s];
            end
            ctrl_q   <= ctrl_d;
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign cpu_rdata_out  = rdata_q;
    assign cpu_rvalid_out = rvalid_q;

    // ============================================================
    // per-source bit selection for the current frame
    logic [E1TOI_NSRC-1:0] src_hit;
    logic [E1TOI_NSRC-1:0] src_bit;
    logic [E1TOI_NSRC-1:0] src_on;

    for (genvar s = 0; s < E1TOI_NSRC; s++) begin : g_src
        e1toi_bit_pick #(
            .ODD_FRAMES (E1TOI_SRC_ODD[s])
        ) u_pick (
            .values_in  (val_q[s]),
            .frame_in   (ts0_frame_in),
            .hit_out    (src_hit[s]),
            .bit_out    (src_bit[s])
        );
        // source drives its lane only when its control bit is set
        assign src_on[s] = ctrl_q[s] && src_hit[s];
    end

    // ============================================================
    // slot-0 byte merge
    logic [7:0] merge_data;
    logic [7:0] merge_mask;

    always_comb begin
        merge_data = ts0_data_in;
        merge_mask = 8'h00;
        for (int s = 0; s < E1TOI_NSRC; s++) begin
            if (src_on[s]) begin
                // sources sharing lane 7 never meet: one odd, one even
                merge_data[E1TOI_SRC_LANE[s]] = src_bit[s];
                merge_mask[E1TOI_SRC_LANE[s]] = 1'b1;
            end
        end
        // lanes left clear keep the upstream framer or backplane value
        merge_data = (merge_data & merge_mask) | (ts0_data_in & ~merge_mask);
    end

    // ============================================================
    // output pipeline, one cycle of latency
    logic       ovalid_q;
    logic       ovalid_d;
    logic [3:0] oframe_q;
    logic [3:0] oframe_d;
    logic [7:0] odata_q;
    logic [7:0] odata_d;
    logic [7:0] omask_q;
    logic [7:0] omask_d;

    always_comb begin
        ovalid_d = ts0_valid_in;
        oframe_d = oframe_q;
        odata_d  = odata_q;
        omask_d  = omask_q;
        // hold the last byte between slots so the line side sees no glitch
        if (ts0_valid_in) begin
            oframe_d = ts0_frame_in;
            odata_d  = merge_data;
            omask_d  = merge_mask;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ovalid_q <= 1'b0;
            oframe_q <= 4'h0;
            odata_q  <= 8'h00;
            omask_q  <= 8'h00;
        end else begin
            ovalid_q <= ovalid_d;
            oframe_q <= oframe_d;
            odata_q  <= odata_d;
            omask_q  <= omask_d;
        end
    end

    assign ts0_valid_out = ovalid_q;
    assign ts0_frame_out = oframe_q;
    assign ts0_data_out  = odata_q;
    assign ts0_mask_out  = omask_q;

endmodule : e1toi_insert

/* pkg/e1toi_pkg.sv */
package e1toi_pkg;

    // ============================================================
    // host register map
    localparam int unsigned E1TOI_ADDR_W     = 8;
    localparam int unsigned E1TOI_DATA_W     = 8;
    localparam logic [7:0]  E1TOI_OFS_SI_AF  = 8'hd2;
    localparam logic [7:0]  E1TOI_OFS_SI_NAF = 8'hd3;
    localparam logic [7:0]  E1TOI_OFS_RA     = 8'hd4;
    localparam logic [7:0]  E1TOI_OFS_SA4    = 8'hd5;
    localparam logic [7:0]  E1TOI_OFS_SA5    = 8'hd6;
    localparam logic [7:0]  E1TOI_OFS_SA6    = 8'hd7;
    localparam logic [7:0]  E1TOI_OFS_SA7    = 8'hd8;
    localparam logic [7:0]  E1TOI_OFS_SA8    = 8'hd9;
    localparam logic [7:0]  E1TOI_OFS_CTRL   = 8'hda;
    localparam logic [7:0]  E1TOI_RST_VAL    = 8'h00;
    localparam logic [7:0]  E1TOI_RST_CTRL   = 8'h00;
    localparam logic [7:0]  E1TOI_UNMAPPED   = 8'h00;

    // ============================================================
    // control bit positions
    localparam int unsigned E1TOI_CTL_SA8    = 0;
    localparam int unsigned E1TOI_CTL_SA7    = 1;
    localparam int unsigned E1TOI_CTL_SA6    = 2;
    localparam int unsigned E1TOI_CTL_SA5    = 3;
    localparam int unsigned E1TOI_CTL_SA4    = 4;
    localparam int unsigned E1TOI_CTL_RA     = 5;
    localparam int unsigned E1TOI_CTL_SI_NAF = 6;
    localparam int unsigned E1TOI_CTL_SI_AF  = 7;

    // ============================================================
    // per-source tables, indexed by control bit position
    localparam int unsigned E1TOI_NSRC = 8;
    localparam int unsigned E1TOI_FRAMES = 16;

    // value register offset of each source
    localparam logic [7:0] E1TOI_SRC_OFS [E1TOI_NSRC] = '{
        E1TOI_OFS_SA8, E1TOI_OFS_SA7, E1TOI_OFS_SA6, E1TOI_OFS_SA5,
        E1TOI_OFS_SA4, E1TOI_OFS_RA, E1TOI_OFS_SI_NAF, E1TOI_OFS_SI_AF};

    // slot-0 byte lane each source overwrites; lane 7 is line bit 1 (sent first)
    localparam logic [2:0] E1TOI_SRC_LANE [E1TOI_NSRC] = '{
        3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7, 3'h7};

    // frame parity a source serves: 1 = odd (nonalign), 0 = even (align)
    localparam logic E1TOI_SRC_ODD [E1TOI_NSRC] = '{
        1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

endpackage : e1toi_pkg

/* rtl/e1toi_bit_pick.sv */
// ============================================================
// selects the stored bit for one frame of the multiframe
module e1toi_bit_pick
    import e1toi_pkg::*;
#(
    parameter logic ODD_FRAMES = 1'b1
) (
    input  wire logic [7:0] values_in,  // stored per-frame values
    input  wire logic [3:0] frame_in,   // frame number 0..15
    output logic            hit_out,    // frame is served by this register
    output logic            bit_out     // value for this frame
);

    logic [2:0] pair_idx;

    always_comb begin
        pair_idx = frame_in[3:1];
        hit_out  = (frame_in[0] == ODD_FRAMES);
        // msb holds the lowest frame, descending order
        bit_out  = values_in[3'h7 - pair_idx];
    end

endmodule : e1toi_bit_pick

/* tb/e1toi_sva.sv */
module e1toi_sva
    import e1toi_pkg::*;
#(
    parameter int unsigned ADDR_W = E1TOI_ADDR_W
) (
    input wire logic              clk_in,         // clock
    input wire logic              srst_in,        // reset
    input wire logic [ADDR_W-1:0] cpu_addr_in,    // address
    input wire logic              cpu_wr_in,      // write
    input wire logic              cpu_rd_in,      // read
    input wire logic [7:0]        cpu_wdata_in,   // wdata
    input wire logic [7:0]        cpu_rdata_out,  // rdata
    input wire logic              cpu_rvalid_out, // rvalid
    input wire logic              ts0_valid_in,   // byte in
    input wire logic [3:0]        ts0_frame_in,   // frame in
    input wire logic [7:0]        ts0_data_in,    // data in
    input wire logic              ts0_valid_out,  // byte out
    input wire logic [3:0]        ts0_frame_out,  // frame out
    input wire logic [7:0]        ts0_data_out,   // data out
    input wire logic [7:0]        ts0_mask_out    // lanes replaced
);
    timeunit 1ns;
    timeprecision 1ps;
    // ============================================================
    // shadow of the control register, so masks can be predicted
    logic [7:0] ctl_q;
    logic [7:0] ctl_d;
    always_comb begin
        ctl_d = ctl_q;
        if (cpu_wr_in && cpu_addr_in == E1TOI_OFS_CTRL) begin
            ctl_d = cpu_wdata_in;
        end
    end
    always_ff @(posedge clk_in) begin
        ctl_q <= srst_in ? E1TOI_RST_CTRL : ctl_d;
    end

    default clocking @(posedge clk_in); endclocking
    default disable iff (srst_in);

    rd_lat_a: assert property (cpu_rd_in |=> cpu_rvalid_out)
        else $error("read answer late");
    rd_quiet_a: assert property (!cpu_rd_in |=> !cpu_rvalid_out && $stable(cpu_rdata_out))
        else $error("read data moved without read");
    unmapped_a: assert property (cpu_rd_in && cpu_addr_in > E1TOI_OFS_CTRL |=> cpu_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    byte_lat_a: assert property (ts0_valid_in |=> ts0_valid_out && ts0_frame_out == $past(ts0_frame_in))
        else $error("byte out late or frame wrong");
    byte_hold_a: assert property (!ts0_valid_in |=> !ts0_valid_out && $stable(ts0_data_out))
        else $error("byte out without byte in");
    pass_thru_a: assert property (ts0_valid_in |=> ((ts0_data_out ^ $past(ts0_data_in)) & ~ts0_mask_out) == 8'h00)
        else $error("unreplaced lane changed");
    odd_mask_a: assert property (ts0_valid_in && ts0_frame_in[0] |=> ts0_mask_out == {$past(ctl_q[6]), 1'b0, $past(ctl_q[5:0])})
        else $error("odd frame mask wrong");
    even_mask_a: assert property (ts0_valid_in && !ts0_frame_in[0] |=> ts0_mask_out == {$past(ctl_q[7]), 7'h00})
        else $error("even frame mask wrong");
endmodule : e1toi_sva

bind e1toi_insert e1toi_sva #(.ADDR_W(ADDR_W)) e1toi_sva_inst (.*);

/* tb/e1toi_src_model.sv */
module e1toi_src_model (
    input  wire logic       clk_in,    // framer clock
    output logic            valid_out, // slot-0 byte strobe
    output logic [3:0]      frame_out, // frame number
    output logic [7:0]      data_out   // slot-0 byte
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        valid_out = 1'b0;
        frame_out = 4'h0;
        data_out  = 8'h00;
    end
    // released between bytes: inverse shown so stale data cannot pass
    task automatic send(input logic [3:0] f, input logic [7:0] d);
        @(negedge clk_in);
        valid_out = 1'b1;
        frame_out = f;
        data_out  = d;
        @(negedge clk_in);
        valid_out = 1'b0;
        data_out  = ~d;
    endtask : send
endmodule : e1toi_src_model

/* tb/e1toi_tb_top.sv */
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module e1toi_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_in  = 1'b0;
    logic       srst_in = 1'b1;
    logic       wr = 1'b0, rd = 1'b0, rvalid, vin, vout;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, din, dout, mask;
    logic [3:0] fin, fout;
    logic [7:0] val [8];
    int         miscompares = 0, n_checks = 0;

    always #5 clk_in = ~clk_in;

    e1toi_insert e1toi_insert_inst (.clk_in(clk_in), .srst_in(srst_in),
        .cpu_addr_in(addr), .cpu_wr_in(wr), .cpu_rd_in(rd), .cpu_wdata_in(wdata),
        .cpu_rdata_out(rdata), .cpu_rvalid_out(rvalid), .ts0_valid_in(vin),
        .ts0_frame_in(fin), .ts0_data_in(din), .ts0_valid_out(vout),
        .ts0_frame_out(fout), .ts0_data_out(dout), .ts0_mask_out(mask));
    e1toi_src_model e1toi_src_model_inst (.clk_in(clk_in), .valid_out(vin),
        .frame_out(fin), .data_out(din));

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        wr = 1'b1; addr = a; wdata = d;
        @(negedge clk_in);
        wr = 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_in);
        rd = 1'b1; addr = a;
        @(negedge clk_in);
        rd = 1'b0;
        d = rdata;
    endtask : reg_rd

    // ============================================================
    // scenarios
    task automatic t_regs;
        logic [7:0] d;
        `CHK({vout, fout, dout, mask, rvalid, rdata}, 29'h0)
        for (int a = 8'hd2; a <= 8'hdb; a++) begin
            reg_rd(8'(a), d);
            `CHK(d, 8'h00)
        end
        // index k follows the control bit; its register sits at d9h - k
        for (int k = 0; k < 8; k++) begin
            val[k] = 8'h5a ^ 8'(k * 39);
            reg_wr(8'hd9 - 8'(k), val[k]);
        end
        reg_wr(8'hdb, 8'hff);
        for (int k = 0; k < 8; k++) begin
            reg_rd(8'hd9 - 8'(k), d);
            `CHK(d, val[k])
        end
        reg_rd(8'hdb, d);
        `CHK(d, 8'h00)
    endtask : t_regs

    task automatic t_insert;
        logic [7:0] ctl, e, m, di;
        logic [3:0] f;
        for (int c = 0; c < 10; c++) begin
            ctl = c < 8 ? 8'h01 << c : (c == 8 ? 8'hff : 8'h00);
            reg_wr(8'hda, ctl);
            for (int i = 0; i < 16; i++) begin
                f  = 4'(i);
                di = {f, ~f};
                e  = di;
                m  = 8'h00;
                for (int k = 0; k < 8; k++) begin
                    if (ctl[k] && (f[0] ^ (k == 7))) begin
                        e[k > 5 ? 7 : k] = val[k][7 - f[3:1]];
                        m[k > 5 ? 7 : k] = 1'b1;
                    end
                end
                e1toi_src_model_inst.send(f, di);
                `CHK(dout, e)
                `CHK({vout, fout, mask}, {1'b1, f, m})
            end
        end
    endtask : t_insert

    // mid-run reset must clear the control and remote alarm registers and the slot-0 outputs
    task automatic t_reset;
        logic [7:0] d;
        reg_wr(8'hda, 8'hff);
        reg_wr(8'hd4, 8'ha5);
        e1toi_src_model_inst.send(4'h1, 8'h00);
        @(negedge clk_in);
        srst_in = 1'b1;
        repeat (2) @(negedge clk_in);
        srst_in = 1'b0;
        `CHK({vout, fout, dout, mask}, 21'h0)
        reg_rd(8'hda, d);
        `CHK(d, 8'h00)
        reg_rd(8'hd4, d);
        `CHK(d, 8'h00)
        e1toi_src_model_inst.send(4'h1, 8'h00);
        `CHK({vout, dout, mask}, 17'h10000)
    endtask : t_reset

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (6) @(posedge clk_in);
        @(negedge clk_in);
        srst_in = 1'b0;
        t_regs();
        t_insert();
        t_reset();
        complete_run();
    end
    initial begin
        #100us;
        miscompares++;
        complete_run();
    end
endmodule : e1toi_tb_top
